// ### hdl/sfl_pkg.sv
// Constants and types shared by the serial flash lane control block.
// Assumes the lane control block and its bench import this package whole; the FIFO does not use it.
package sfl_pkg;
	// Protocol and per-command lane width codes
	localparam logic [1:0] PROTO_EXT = 2'h0;
	localparam logic [1:0] PROTO_DUAL = 2'h1;
	localparam logic [1:0] PROTO_QUAD = 2'h2;
	localparam logic [1:0] CW_SINGLE = 2'h0;
	localparam logic [1:0] CW_DUAL = 2'h1;
	localparam logic [1:0] CW_QUAD = 2'h2;
	// Configuration and status bit positions
	localparam int CFG_PAUSE_BIT = 4;
	localparam logic CFG_PAUSE_OFF = 1'h0;
	localparam int SR_WD_BIT = 7;
	// Synchroniser vector {dq[3:0], pause_n, cs_n, sck}
	localparam int SYNC_W = 7;
	localparam int PIN_SCK = 0;
	localparam int PIN_CS = 1;
	localparam int PIN_PAUSE = 2;
	localparam int PIN_DQ0 = 3;
	localparam int PIN_WP = 5;
	localparam logic [6:0] SYNC_RST = 7'h00;
	// Byte framing and lane enable masks (low = driven)
	localparam int BYTE_W = 8;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam int FIFO_DEPTH = 16;
	localparam logic [3:0] OE_NONE = 4'hf;
	localparam logic [3:0] OE_SINGLE = 4'hd;
	localparam logic [3:0] OE_DUAL = 4'hc;
	localparam logic [3:0] OE_QUAD = 4'h0;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_CMD = 3'h2,
		ST_BODY = 3'h4
	} sfl_state_type;
endpackage

// ### hdl/sfl_fifo.sv
// Receive FIFO: circular store plus one registered output stage.
// Assumes writer and reader share i_clk; both sides use valid/ready.
`timescale 1ns/1ns
module sfl_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// Fill side
	input wire logic i_wr_valid,
	input wire logic [WIDTH-1:0] i_wr_data,
	output logic o_wr_ready,
	// Drain side
	output logic o_rd_valid,
	output logic [WIDTH-1:0] o_rd_data,
	input wire logic i_rd_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff, rd_ptr_ff, nxt_wr_ptr, nxt_rd_ptr;
	logic [AW:0] cnt_ff, nxt_cnt;
	logic out_valid_ff, nxt_out_valid;
	logic [WIDTH-1:0] out_data_ff, nxt_out_data;
	logic push, pop;

	////////////////////////////////////////////////////////////////////
	always_comb begin
		push = i_wr_valid && (cnt_ff != FULL_CNT);
		pop = (cnt_ff != '0) && (!out_valid_ff || i_rd_ready);
		nxt_wr_ptr = push ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
		nxt_rd_ptr = pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
		nxt_cnt = cnt_ff;
		if (push && !pop) begin
			nxt_cnt = (AW + 1)'(cnt_ff + 1'b1);
		end else if (pop && !push) begin
			nxt_cnt = (AW + 1)'(cnt_ff - 1'b1);
		end
		nxt_out_valid = out_valid_ff;
		nxt_out_data = out_data_ff;
		if (pop) begin
			nxt_out_valid = 1'b1;
			nxt_out_data = mem_ff[rd_ptr_ff];
		end else if (i_rd_ready) begin
			nxt_out_valid = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff <= '0;
			out_valid_ff <= 1'b0;
			out_data_ff <= '0;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			cnt_ff <= nxt_cnt;
			out_valid_ff <= nxt_out_valid;
			out_data_ff <= nxt_out_data;
		end
	end

	// Storage has no reset; only the pointers and count say what is valid
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= i_wr_data;
		end
	end

	assign o_wr_ready = (cnt_ff != FULL_CNT);
	assign o_rd_valid = out_valid_ff;
	assign o_rd_data = out_data_ff;
endmodule

// ### hdl/sfl_lane_ctrl.sv
// Pin-side lane control of a serial flash: select, pause, write protect
// and single/dual/quad lane steering, oversampled on i_clk.
// Assumes the serial clock is well below i_clk / 4 and the core decodes
// commands from the received byte stream.
`timescale 1ns/1ns
// Operation
// R1: Pause asserted suspends transfer, stays selected, tri-states, ignores inputs.
// R2: Config bit 4 (nonvolatile or enhanced volatile) disables the pause function.
// R3: Shared pause pin is ignored in quad protocol or double rate.
// R4: Write-disable bit set and protect pin low blocks status writes.
// R5: Protect pin acts as bidirectional lane 2 in quad commands and protocol.
// R6: Host must always drive the protect pin; no internal pull-up.
// R7: Single-lane commands: lane 0 input, lane 1 output, lanes 3:2 unused.
// R8: Dual commands and dual protocol use lanes 1:0 both ways only.
// R9: Quad commands and quad protocol use all four lanes both ways.
// R10: Select high means standby, tri-state; first command needs a falling select. Code holds o_standby low while i_busy.
// R11: Command on rising edges; single rate samples rise; double rate both.
// R12: Host drives lane 3 high in single/dual use when pin is shared.
// R13: Releasing pause resumes at the same bit, progress kept.
module sfl_lane_ctrl #(
	parameter bit SHARED_PAUSE = 1'b1,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// Flash pins
	input wire logic i_cs_n,
	input wire logic i_sck,
	input wire logic i_pause_n,
	input wire logic [3:0] i_dq,
	output logic [3:0] o_dq,
	output logic [3:0] o_dq_oe_n,
	// Core configuration
	input wire logic [1:0] i_protocol,
	input wire logic i_dtr_en,
	input wire logic [7:0] i_nvcfg,
	input wire logic [7:0] i_evcfg,
	input wire logic [7:0] i_status,
	input wire logic i_busy,
	input wire logic [1:0] i_cmd_width,
	input wire logic i_out_phase,
	// Status register write gate
	input wire logic i_sr_write_req,
	output logic o_sr_write_go,
	output logic o_sr_protected,
	// Received bytes {is_command, byte}
	output logic o_rx_valid,
	output logic [sfl_pkg::BYTE_W:0] o_rx_data,
	input wire logic i_rx_ready,
	output logic o_rx_overflow,
	// Bytes to send
	input wire logic i_tx_valid,
	input wire logic [sfl_pkg::BYTE_W-1:0] i_tx_data,
	output logic o_tx_take,
	// Pin state
	output logic o_standby,
	output logic o_paused
);
	import sfl_pkg::*;

	logic [SYNC_W-1:0] sync1_ff, sync2_ff;
	logic sck_d_ff, cs_d_ff;
	sfl_state_type state_ff, nxt_state;
	logic [7:0] rx_sh_ff, nxt_rx_sh, tx_sh_ff, nxt_tx_sh, shifted;
	logic [3:0] rx_cnt_ff, nxt_rx_cnt, tx_cnt_ff, nxt_tx_cnt, lanes, sum;
	logic pend_valid_ff, nxt_pend_valid, pend_cmd_ff, nxt_pend_cmd;
	logic [7:0] pend_data_ff, nxt_pend_data;
	logic [3:0] dq_ff, nxt_dq, oe_n_ff, nxt_oe_n, drive_mask;
	logic ovf_ff, nxt_ovf, take_ff, nxt_take;
	logic prot_ff, nxt_prot, go_ff, nxt_go, stby_ff, paused_ff;
	logic sck_s, cs_n_s, rise, fall, cs_fall, pause_dis, pause_act;
	logic sample, out_edge, drive, fifo_ready;
	logic [1:0] wc;
	logic [3:0] dq_s;

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers; first stage feeds only the second
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			sync1_ff <= SYNC_RST;
			sync2_ff <= SYNC_RST;
			sck_d_ff <= 1'b0;
			cs_d_ff <= 1'b0;
		end else begin
			sync1_ff <= {i_dq, i_pause_n, i_cs_n, i_sck};
			sync2_ff <= sync1_ff;
			sck_d_ff <= sync2_ff[PIN_SCK];
			cs_d_ff <= sync2_ff[PIN_CS];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Edge, pause and lane decode
	always_comb begin
		sck_s = sync2_ff[PIN_SCK];
		cs_n_s = sync2_ff[PIN_CS];
		dq_s = sync2_ff[PIN_DQ0+3:PIN_DQ0];
		rise = sck_s && !sck_d_ff;
		fall = !sck_s && sck_d_ff;
		// Select held low through reset is not a falling edge
		cs_fall = cs_d_ff && !cs_n_s; // R10
		pause_dis = (i_nvcfg[CFG_PAUSE_BIT] == CFG_PAUSE_OFF) ||
			(i_evcfg[CFG_PAUSE_BIT] == CFG_PAUSE_OFF); // R2
		pause_act = !sync2_ff[PIN_PAUSE] && !pause_dis && !(SHARED_PAUSE &&
			(i_protocol == PROTO_QUAD || i_dtr_en)); // R1 R3
		if (i_protocol == PROTO_QUAD) begin
			wc = CW_QUAD; // R9
		end else if (i_protocol == PROTO_DUAL) begin
			wc = CW_DUAL; // R8
		end else if (state_ff == ST_BODY) begin
			wc = i_cmd_width;
		end else begin
			wc = CW_SINGLE; // R7
		end
		lanes = 4'h1 << wc;
		unique case (wc)
			CW_DUAL: drive_mask = OE_DUAL; // R8
			CW_QUAD: drive_mask = OE_QUAD; // R5 R9
			default: drive_mask = OE_SINGLE; // R7
		endcase
		// Command bits only on rising edges; double rate body on both
		sample = (state_ff == ST_BODY && i_dtr_en) ? (rise || fall) : rise; // R11
		out_edge = (state_ff == ST_BODY) && i_out_phase &&
			(i_dtr_en ? (rise || fall) : fall); // R11
		drive = (state_ff == ST_BODY) && i_out_phase && !cs_n_s && !pause_act;
		sum = 4'(rx_cnt_ff + lanes);
		unique case (wc)
			CW_DUAL: shifted = {rx_sh_ff[5:0], dq_s[1:0]};
			CW_QUAD: shifted = {rx_sh_ff[3:0], dq_s};
			default: shifted = {rx_sh_ff[6:0], dq_s[0]}; // R7
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Transfer state, next values
	always_comb begin
		nxt_state = state_ff;
		nxt_rx_sh = rx_sh_ff;
		nxt_rx_cnt = rx_cnt_ff;
		nxt_tx_sh = tx_sh_ff;
		nxt_tx_cnt = tx_cnt_ff;
		nxt_dq = dq_ff;
		nxt_take = 1'b0;
		nxt_pend_valid = pend_valid_ff && !fifo_ready;
		nxt_pend_cmd = pend_cmd_ff;
		nxt_pend_data = pend_data_ff;
		nxt_ovf = ovf_ff;
		nxt_oe_n = drive ? drive_mask : OE_NONE; // R1 R10
		unique case (state_ff)
			ST_IDLE: begin
				if (cs_fall) begin
					nxt_state = ST_CMD; // R10
					nxt_rx_cnt = '0;
					nxt_tx_cnt = '0;
					nxt_ovf = 1'b0;
				end
			end
			ST_CMD, ST_BODY: begin
				if (cs_n_s) begin
					nxt_state = ST_IDLE; // R10
				end else if (pause_act) begin
					// Counters and shifters frozen until release
					nxt_state = state_ff; // R13
				end else begin
					if (sample) begin
						nxt_rx_sh = shifted;
						nxt_rx_cnt = sum;
						if (sum == BYTE_BITS) begin
							nxt_rx_cnt = '0;
							nxt_state = ST_BODY;
							// Full holding slot: new byte dropped, older kept
							if (pend_valid_ff && !fifo_ready) begin
								nxt_ovf = 1'b1;
							end else begin
								nxt_pend_valid = 1'b1;
								nxt_pend_cmd = (state_ff == ST_CMD);
								nxt_pend_data = shifted;
							end
						end
					end
					if (state_ff == ST_BODY && i_out_phase) begin
						if (tx_cnt_ff == '0 && i_tx_valid) begin
							nxt_tx_sh = i_tx_data;
							nxt_tx_cnt = BYTE_BITS;
							nxt_take = 1'b1;
						end else if (out_edge && tx_cnt_ff != '0) begin
							unique case (wc)
								CW_DUAL: nxt_dq[1:0] = tx_sh_ff[7:6]; // R8
								CW_QUAD: nxt_dq = tx_sh_ff[7:4]; // R5 R9
								default: nxt_dq[1] = tx_sh_ff[7]; // R7
							endcase
							nxt_tx_sh = tx_sh_ff << lanes;
							nxt_tx_cnt = 4'(tx_cnt_ff - lanes);
						end
					end
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
		nxt_prot = i_status[SR_WD_BIT] && !sync2_ff[PIN_WP]; // R4
		nxt_go = i_sr_write_req && !nxt_prot; // R4
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state_ff <= ST_IDLE;
			rx_sh_ff <= '0;
			rx_cnt_ff <= '0;
			tx_sh_ff <= '0;
			tx_cnt_ff <= '0;
			dq_ff <= '0;
			oe_n_ff <= OE_NONE;
			take_ff <= 1'b0;
			pend_valid_ff <= 1'b0;
			pend_cmd_ff <= 1'b0;
			pend_data_ff <= '0;
			ovf_ff <= 1'b0;
			prot_ff <= 1'b0;
			go_ff <= 1'b0;
			stby_ff <= 1'b1;
			paused_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			rx_sh_ff <= nxt_rx_sh;
			rx_cnt_ff <= nxt_rx_cnt;
			tx_sh_ff <= nxt_tx_sh;
			tx_cnt_ff <= nxt_tx_cnt;
			dq_ff <= nxt_dq;
			oe_n_ff <= nxt_oe_n;
			take_ff <= nxt_take;
			pend_valid_ff <= nxt_pend_valid;
			pend_cmd_ff <= nxt_pend_cmd;
			pend_data_ff <= nxt_pend_data;
			ovf_ff <= nxt_ovf;
			prot_ff <= nxt_prot;
			go_ff <= nxt_go;
			stby_ff <= (nxt_state == ST_IDLE) && !i_busy; // R10
			paused_ff <= pause_act && (state_ff != ST_IDLE) && !cs_n_s; // R1
		end
	end

	////////////////////////////////////////////////////////////////////
	// Receive buffer toward the core
	sfl_fifo #(
		.WIDTH(BYTE_W + 1),
		.DEPTH(DEPTH)
	) u_rx_fifo (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_wr_valid(pend_valid_ff),
		.i_wr_data({pend_cmd_ff, pend_data_ff}),
		.o_wr_ready(fifo_ready),
		.o_rd_valid(o_rx_valid),
		.o_rd_data(o_rx_data),
		.i_rd_ready(i_rx_ready)
	);

	assign o_dq = dq_ff;
	assign o_dq_oe_n = oe_n_ff;
	assign o_tx_take = take_ff;
	assign o_rx_overflow = ovf_ff;
	assign o_sr_protected = prot_ff;
	assign o_sr_write_go = go_ff;
	assign o_standby = stby_ff;
	assign o_paused = paused_ff;

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	sequence seq_busy;
		(state_ff != ST_IDLE) && !cs_n_s;
	endsequence
	sequence seq_paused;
		seq_busy ##0 pause_act;
	endsequence
	chk_pause_tristate: assert property (seq_paused |=> o_dq_oe_n == OE_NONE && o_paused) // R1
		else $error("lanes driven during pause");
	chk_pause_keeps: assert property (seq_paused |=> $stable(rx_cnt_ff) && $stable(rx_sh_ff)) // R13
		else $error("progress lost during pause");
	chk_pause_cfg_off: assert property (seq_busy ##0 pause_dis |=> !o_paused) // R2
		else $error("pause active though disabled");
	chk_shared_pause: assert property (SHARED_PAUSE && i_protocol == PROTO_QUAD |=> !o_paused) // R3
		else $error("shared pause honoured in quad");
	chk_sr_lock: assert property (i_status[SR_WD_BIT] && !sync2_ff[PIN_WP] && i_sr_write_req |=> o_sr_protected && !o_sr_write_go) // R4
		else $error("status write not blocked");
	chk_single_lanes: assert property (drive && wc == CW_SINGLE |=> o_dq_oe_n == OE_SINGLE) // R7
		else $error("single lane drive wrong");
	chk_dual_lanes: assert property (drive && wc == CW_DUAL |=> o_dq_oe_n == OE_DUAL) // R8
		else $error("dual lane drive wrong");
	chk_quad_lanes: assert property (drive && wc == CW_QUAD |=> o_dq_oe_n == OE_QUAD) // R5 R9
		else $error("quad lane drive wrong");
	chk_deselect_idle: assert property (cs_n_s && state_ff != ST_IDLE |=> state_ff == ST_IDLE && o_dq_oe_n == OE_NONE ##1 o_standby || i_busy) // R10
		else $error("no standby after deselect");
	chk_need_fall: assert property (state_ff == ST_IDLE && !cs_fall |=> state_ff == ST_IDLE) // R10
		else $error("command started without falling select");
	chk_cmd_rise: assert property (state_ff == ST_CMD && fall && !cs_n_s |=> $stable(rx_cnt_ff)) // R11
		else $error("command bit taken on falling edge");
endmodule

// ### test/sfl_host_model.sv
// Host controller model: select, serial clock and the four lanes.
// Assumes the bench calls its tasks; lanes resolve against device enables.
`timescale 1ns/1ns
module sfl_host_model #(
	parameter int HALF = 6
) (
	// Clock
	input wire logic i_clk,
	// Device lane outputs
	input wire logic [3:0] i_dev_dq,
	input wire logic [3:0] i_dev_oe_n,
	// Pins
	output logic o_cs_n,
	output logic o_sck,
	output logic [3:0] o_dq
);
	logic [3:0] drv = 4'hc;
	logic [3:0] hen = 4'hf;
	logic [3:0] last_ff;
	initial begin
		o_cs_n = 1'b1;
		o_sck = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////
	// Released lanes show the inverse of their last level
	always_ff @(posedge i_clk) begin
		last_ff <= o_dq;
	end
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			o_dq[i] = !i_dev_oe_n[i] ? i_dev_dq[i] : (hen[i] ? drv[i] : ~last_ff[i]);
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic sel(input logic v);
		@(posedge i_clk);
		o_cs_n <= v;
		repeat (8) @(posedge i_clk);
	endtask
	// Protect pin and lane 3 go back high whenever enables change
	task automatic set_en(input logic [3:0] e);
		hen <= e;
		drv <= 4'hc;
	endtask
	// Shift on the falling edge, sample on the rising edge
	task automatic xfer(input int lanes, input int steps,
		input logic [7:0] tx, output logic [7:0] rx);
		logic [7:0] sr;
		sr = tx;
		rx = 8'h00;
		repeat (steps) begin
			@(posedge i_clk);
			o_sck <= 1'b0;
			case (lanes)
				1: drv[0] <= sr[7];
				2: drv[1:0] <= sr[7:6];
				default: drv <= sr[7:4];
			endcase
			sr = sr << lanes;
			repeat (HALF) @(posedge i_clk);
			o_sck <= 1'b1;
			case (lanes)
				1: rx = {rx[6:0], o_dq[1]};
				2: rx = {rx[5:0], o_dq[1:0]};
				default: rx = {rx[3:0], o_dq};
			endcase
			repeat (HALF - 1) @(posedge i_clk);
		end
	endtask
endmodule

// ### test/sfl_lane_ctrl_tb.sv
// Self-checking bench of the lane control block against a host model.
// Assumes one 100 MHz clock; expected words queue up as the host sends.
`timescale 1ns/1ns
module sfl_lane_ctrl_tb;
	import sfl_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic cs_n, sck, pause_n = 1'b1, busy = 1'b0, dtr = 1'b0;
	logic [3:0] dq, dev_dq, dev_oe_n;
	logic [1:0] proto = PROTO_EXT, cw = CW_SINGLE;
	logic [7:0] nvcfg = 8'h10, evcfg = 8'h10, status = 8'h00, tx_data = 8'h00;
	logic out_ph = 1'b0, sr_req = 1'b0, rx_ready = 1'b1, tx_valid = 1'b0;
	logic rx_valid, rx_ovf, tx_take, standby, paused, sr_go, sr_prot;
	logic [8:0] rx_data;
	logic [8:0] exp_q[$];
	logic [7:0] b, got, r8;
	logic bz;
	int bad_count = 0, checked = 0, drained = 0, cycles = 0;

	sfl_host_model host_u (.i_clk(clk), .i_dev_dq(dev_dq),
		.i_dev_oe_n(dev_oe_n), .o_cs_n(cs_n), .o_sck(sck), .o_dq(dq));
	sfl_lane_ctrl dut_u (.i_clk(clk), .i_srst(srst), .i_cs_n(cs_n),
		.i_sck(sck), .i_pause_n(pause_n), .i_dq(dq), .o_dq(dev_dq),
		.o_dq_oe_n(dev_oe_n), .i_protocol(proto), .i_dtr_en(dtr),
		.i_nvcfg(nvcfg), .i_evcfg(evcfg), .i_status(status), .i_busy(busy),
		.i_cmd_width(cw), .i_out_phase(out_ph), .i_sr_write_req(sr_req),
		.o_sr_write_go(sr_go), .o_sr_protected(sr_prot),
		.o_rx_valid(rx_valid), .o_rx_data(rx_data), .i_rx_ready(rx_ready),
		.o_rx_overflow(rx_ovf), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
		.o_tx_take(tx_take), .o_standby(standby), .o_paused(paused));

	initial begin
		forever #5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic cmp(input string nm, input logic [8:0] e,
		input logic [8:0] g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic close_out();
		if (bad_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	function automatic logic [3:0] oe_of(input int w);
		return w == 0 ? OE_SINGLE : (w == 1 ? OE_DUAL : OE_QUAD);
	endfunction
	task automatic wait_take();
		int n;
		n = 0;
		while (tx_take !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		cmp("tx_take", 1'b1, tx_take);
		tx_valid <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
			drained++;
			cmp("rx_pending", 9'h001, 9'(exp_q.size() != 0));
			if (exp_q.size() != 0) begin
				cmp("rx_word", exp_q.pop_front(), rx_data);
			end
		end
	end
	// Whole run needs under two thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			close_out();
		end
	end
	initial begin
		void'($urandom(84866));
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		cmp("oe_reset", OE_NONE, dev_oe_n);
		cmp("standby", 1'b1, standby);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			r8 = 8'($urandom);
			r8[SR_WD_BIT] = i[2];
			status <= r8;
			sr_req <= i[0];
			host_u.drv[2] <= i[1];
			repeat (6) @(posedge clk);
			cmp("sr_prot", i[2] & !i[1], sr_prot);
			cmp("sr_go", i[0] & !(i[2] & !i[1]), sr_go);
		end
		sr_req <= 1'b0;
		host_u.set_en(4'hf);
		for (int w = 0; w < 3; w++) begin
			cw <= w[1:0];
			rx_ready <= 1'($urandom);
			host_u.sel(1'b0);
			b = 8'($urandom);
			exp_q.push_back({1'b1, b});
			host_u.xfer(1, 8, b, got);
			b = 8'($urandom);
			exp_q.push_back({1'b0, b});
			host_u.xfer(1 << w, 8 >> w, b, got);
			host_u.set_en(oe_of(w));
			b = 8'($urandom);
			tx_data <= b;
			tx_valid <= 1'b1;
			out_ph <= 1'b1;
			wait_take();
			// Device still samples its lanes; wide modes hear the sent byte
			exp_q.push_back({1'b0, w == 0 ? 8'h00 : b});
			host_u.xfer(1 << w, 8 >> w, 8'h00, got);
			cmp("tx_byte", b, got);
			cmp("oe_out", oe_of(w), dev_oe_n);
			out_ph <= 1'b0;
			host_u.set_en(4'hf);
			host_u.sel(1'b1);
			cmp("oe_idle", OE_NONE, dev_oe_n);
		end
		cw <= CW_SINGLE;
		rx_ready <= 1'b1;
		host_u.sel(1'b0);
		b = 8'($urandom);
		exp_q.push_back({1'b1, b});
		host_u.xfer(1, 4, b, got);
		pause_n <= 1'b0;
		repeat (8) @(posedge clk);
		cmp("paused", 1'b1, paused);
		host_u.xfer(1, 2, 8'h00, got);
		pause_n <= 1'b1;
		repeat (8) @(posedge clk);
		host_u.xfer(1, 4, b << 4, got);
		// Pause while the output lane would be driven
		out_ph <= 1'b1;
		repeat (8) @(posedge clk);
		cmp("oe_drive", OE_SINGLE, dev_oe_n);
		pause_n <= 1'b0;
		repeat (8) @(posedge clk);
		cmp("oe_pause", OE_NONE, dev_oe_n);
		pause_n <= 1'b1;
		out_ph <= 1'b0;
		repeat (8) @(posedge clk);
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			r8 = 8'($urandom);
			r8[CFG_PAUSE_BIT] = (k != 0);
			nvcfg <= r8;
			r8 = 8'($urandom);
			r8[CFG_PAUSE_BIT] = (k != 1);
			evcfg <= r8;
			proto <= k == 2 ? PROTO_QUAD : PROTO_EXT;
			dtr <= (k == 3);
			pause_n <= 1'b0;
			repeat (8) @(posedge clk);
			cmp("pause_off", 1'b0, paused);
			pause_n <= 1'b1;
		end
		dtr <= 1'b0;
		host_u.sel(1'b1);
		for (int n = 0; n < 4; n++) begin
			bz = (n == 0) ? 1'b1 : 1'($urandom);
			busy <= bz;
			repeat (6) @(posedge clk);
			cmp("standby_busy", !bz, standby);
		end
		busy <= 1'b0;
		cmp("rx_left", 9'h000, 9'(exp_q.size()));
		// Fill past capacity with the reader stalled, then drain
		rx_ready <= 1'b0;
		cw <= CW_QUAD;
		drained = 0;
		host_u.sel(1'b0);
		for (int j = 0; j < 20; j++) begin
			b = 8'($urandom);
			exp_q.push_back({j == 0, b});
			host_u.xfer(j == 0 ? 1 : 4, j == 0 ? 8 : 2, b, got);
		end
		repeat (8) @(posedge clk);
		cmp("overflow", 1'b1, rx_ovf);
		rx_ready <= 1'b1;
		repeat (60) @(posedge clk);
		// Output stage and holding slot add two to the store
		cmp("drained", 9'(FIFO_DEPTH + 2), 9'(drained));
		exp_q.delete();
		host_u.sel(1'b1);
		host_u.sel(1'b0);
		cmp("ovf_clear", 1'b0, rx_ovf);
		host_u.sel(1'b1);
		close_out();
	end
endmodule
